// ---- hw/trocm_pkg.sv ----
// Package for the tunable RC oscillator control and measurement block.
// Assumes byte-wide registers on a 16-bit address bus and a single system clock.
package trocm_pkg;

    // Register addresses.
    localparam logic [15:0] OSC_CTRL_ADDR = 16'hfeb4;
    localparam logic [15:0] CNT_LO_ADDR   = 16'hfeb5;
    localparam logic [15:0] CNT_MID_ADDR  = 16'hfeb6;
    localparam logic [15:0] CNT_HI_ADDR   = 16'hfeb7;

    // Oscillator control register fields.
    localparam int SEL_BIT    = 7;
    localparam int RUN_BIT    = 6;
    localparam int COARSE_LSB = 3;
    localparam int FINE_LSB   = 0;
    localparam int TRIM_W     = 3;

    // Measurement control and high count register fields.
    localparam int EN_BIT    = 7;
    localparam int DONE_BIT  = 6;
    localparam int RANGE_BIT = 5;
    localparam int TEST_BIT  = 4;
    localparam int OVF_BIT   = 3;

    // Counter width; the top bit is the sticky overflow flag.
    localparam int CNT_W = 20;

    // Reset values.
    localparam logic [7:0] OSC_CTRL_RST = 8'h00;
    localparam logic [7:0] CNT_HI_RST   = 8'h00;

    // Trim codes that give the nominal center frequency.
    localparam logic [2:0] CENTER_COARSE = 3'h4;
    localparam logic [2:0] CENTER_FINE   = 3'h0;

    // Center range select codes: about 10 MHz or about 4 MHz.
    localparam logic RANGE_10MHZ = 1'b0;
    localparam logic RANGE_4MHZ  = 1'b1;

    // System clock pause length in clock periods, chosen inside 2 to 4.
    localparam logic [1:0] PAUSE_CYC = 2'h3;

    // Measurement sequencer states.
    typedef enum logic [1:0] {
        MS_IDLE  = 2'b00,
        MS_ARM   = 2'b01,
        MS_COUNT = 2'b10,
        MS_DONE  = 2'b11
    } trocm_meas_state_t;

endpackage

// ---- hw/trocm_evt_if.sv ----
// Interface between the core and its edge detector and pause timer.
// Assumes all three run on the same system clock.
`timescale 1ns/1ps
interface trocm_evt_if;
    logic ref_rise;
    logic pause_trig;
    logic pause_act;

    modport edge_det (output ref_rise);
    modport pause    (input pause_trig, output pause_act);
    modport core     (input ref_rise, input pause_act, output pause_trig);
endinterface

// ---- hw/trocm_ref_edge.sv ----
// Synchroniser and rising-edge detector for the reference input pin.
// Assumes the pin may be asynchronous; the edge pulse is one clock long.
`timescale 1ns/1ps
module trocm_ref_edge (
    // Clock and reset.
    input wire logic      clk,
    input wire logic      rst,
    // Reference pin and edge output.
    input wire logic      ref_in,
    trocm_evt_if.edge_det evt
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } trocm_edge_state_t;

    trocm_edge_state_t cur_ff;
    trocm_edge_state_t nxt_ff;

    // The first stage feeds only the second; the edge is taken from later stages.
    always_comb begin
        nxt_ff    = cur_ff;
        nxt_ff.s1 = ref_in;
        nxt_ff.s2 = cur_ff.s1;
        nxt_ff.s3 = cur_ff.s2;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign evt.ref_rise = cur_ff.s2 & ~cur_ff.s3; // RULE_22

    property p_rise_single;
        @(posedge clk) disable iff (rst)
        evt.ref_rise |=> !evt.ref_rise;
    endproperty
    a_rise_single: assert property (p_rise_single) else $error("edge pulse longer than one cycle"); // RULE_22

endmodule

// ---- hw/trocm_pause.sv ----
// Pause timer that holds the system clock gate for a fixed number of periods.
// Assumes the trigger is a one-cycle pulse; a retrigger restarts the count.
`timescale 1ns/1ps
module trocm_pause (
    // Clock and reset.
    input wire logic   clk,
    input wire logic   rst,
    // Trigger in, pause level out.
    trocm_evt_if.pause evt
);

    typedef struct packed {
        logic [1:0] cnt;
    } trocm_pause_state_t;

    trocm_pause_state_t cur_ff;
    trocm_pause_state_t nxt_ff;

    // Load on a trigger and count down to zero.
    always_comb begin
        nxt_ff = cur_ff;
        if (evt.pause_trig) begin
            nxt_ff.cnt = trocm_pkg::PAUSE_CYC; // RULE_17
        end else if (cur_ff.cnt != 2'h0) begin
            nxt_ff.cnt = cur_ff.cnt - 2'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign evt.pause_act = (cur_ff.cnt != 2'h0);

    sequence s_trig_alone;
        evt.pause_trig ##1 (!evt.pause_trig)[*3];
    endsequence

    property p_pause_len;
        @(posedge clk) disable iff (rst)
        s_trig_alone |-> $past(evt.pause_act, 2) && $past(evt.pause_act) && evt.pause_act ##1 !evt.pause_act;
    endproperty
    a_pause_len: assert property (p_pause_len) else $error("pause is not three periods"); // RULE_17

endmodule

// ---- hw/trocm_core.sv ----
// Register file, measurement sequencer and clock controls for the tunable RC
// oscillator. Assumes OSC_TICK pulses once per oscillator period, already in
// the system clock domain, and that hold-mode entry arrives as a one-cycle pulse.
`timescale 1ns/1ps

// Overview of operation
// [RULE_01] A 20-bit oscillator clock counter with a 4-bit control field.
// [RULE_02] With enable set and oscillator running, count clocks over one reference period.
// [RULE_03] Count bits 7..0 low, 15..8 middle, 18..16 in high bits 2..0.
// [RULE_04] Counter bit 19 is a sticky overflow flag at high bit 3.
// [RULE_05] Low and middle read-only; high bits 6 and 3..0 ignore writes.
// [RULE_06] Writing enable 0 stops measurement and clears count, overflow and done; here overflow or done set by hardware in the same cycle stays set.
// [RULE_07] Done flag sets when measurement ends and stays until enable is cleared.
// [RULE_08] After done, no new measurement until enable is cleared and set again.
// [RULE_09] Software reads results only after done, then clears the enable.
// [RULE_10] Range select 0 gives about 10 MHz center, 1 about 4 MHz.
// [RULE_11] Software leaves the range select alone while the oscillator clocks the system.
// [RULE_12] Software always writes 0 to the reserved test bit.
// [RULE_13] Main select 1 picks the tunable oscillator, 0 the ceramic one.
// [RULE_14] Run bit starts or stops the oscillator; full hold clears it.
// [RULE_15] Control holds 3-bit coarse trim in bits 5..3, fine in 2..0.
// [RULE_16] Coarse 4 with fine 0 is the nominal center frequency.
// [RULE_17] System clock pauses when the oscillator becomes or is rewritten as source.
// [RULE_18] Software waits 10 us after start before selecting the oscillator.
// [RULE_19] Software moves the system clock off this oscillator before crystal hold.
// [RULE_20] Software uses measurement to keep trims within the allowed frequency.
// [RULE_21] Oscillator stopped at reset and full hold, kept through halt and crystal hold.
// [RULE_22] Reference input is synchronised; counting runs edge to next rising edge.
// [RULE_23] Overflow stays set until enable clears; the count is then unreliable.
module trocm_core (
    // Clock and reset.
    input  wire logic        SYS_CLK,
    input  wire logic        SYS_RST,
    // Register port.
    input  wire logic [15:0] ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output wire logic [7:0]  RDATA,
    // Oscillator and reference events.
    input  wire logic        OSC_TICK,
    input  wire logic        REF_IN,
    // System clock and power state.
    input  wire logic        SYS_CLK_IS_MAIN,
    input  wire logic        FULL_HOLD_ENTRY,
    // Oscillator controls.
    output wire logic        OSC_RUN,
    output wire logic        MAIN_CLK_SRC_SEL,
    output wire logic [2:0]  COARSE_TRIM,
    output wire logic [2:0]  FINE_TRIM,
    output wire logic        CENTER_RANGE_SEL,
    output wire logic        TRIM_AT_CENTER,
    output wire logic        SYS_CLK_PAUSE
);

    localparam int CW = trocm_pkg::CNT_W - 1;

    typedef struct packed {
        logic                         sel;
        logic                         run;
        logic [2:0]                   coarse;
        logic [2:0]                   fine;
        logic                         en;
        logic                         done;
        logic                         range_sel;
        logic                         test;
        logic                         ovf;
        logic [CW-1:0]                cnt;
        trocm_pkg::trocm_meas_state_t st;
        logic                         serv_q;
        logic                         at_ctr;
        logic [7:0]                   rdata;
    } trocm_core_state_t;

    trocm_core_state_t cur_ff;
    trocm_core_state_t nxt_ff;

    trocm_evt_if evt ();

    logic          wr_ctrl;
    logic          wr_hi;
    logic          clr;
    logic          serving;
    logic [CW:0]   inc;
    logic          done_set;
    logic          ovf_set;

    // Reference pin synchroniser and edge detector.
    trocm_ref_edge u_edge (
        .clk    (SYS_CLK),
        .rst    (SYS_RST),
        .ref_in (REF_IN),
        .evt    (evt.edge_det)
    );

    // Pause timer for the system clock gate.
    trocm_pause u_pause (
        .clk (SYS_CLK),
        .rst (SYS_RST),
        .evt (evt.pause)
    );

    // Address decode; every access is single-cycle so the master never waits.
    assign wr_ctrl = WR && (ADDR == trocm_pkg::OSC_CTRL_ADDR);
    assign wr_hi   = WR && (ADDR == trocm_pkg::CNT_HI_ADDR);
    assign clr     = wr_hi && !WDATA[trocm_pkg::EN_BIT];

    // The oscillator clocks the system only when both selects are set.
    assign serving = cur_ff.sel && SYS_CLK_IS_MAIN; // RULE_13

    // Becoming the source, or a control write while it is, stalls the clock.
    assign evt.pause_trig = serving && (wr_ctrl || !cur_ff.serv_q); // RULE_17

    assign inc = {1'b0, cur_ff.cnt} + {{CW{1'b0}}, 1'b1};

    // Hardware set events for the two flags; each wins over a same-cycle clear.
    assign done_set = (cur_ff.st == trocm_pkg::MS_COUNT) && evt.ref_rise; // RULE_07
    assign ovf_set  = (cur_ff.st == trocm_pkg::MS_COUNT) && OSC_TICK && inc[CW]; // RULE_04

    // Next-state logic for registers, sequencer and read data.
    always_comb begin
        nxt_ff        = cur_ff;
        nxt_ff.serv_q = serving;
        // Oscillator control register; all eight bits are writable.
        if (wr_ctrl) begin
            nxt_ff.sel    = WDATA[trocm_pkg::SEL_BIT]; // RULE_13
            nxt_ff.run    = WDATA[trocm_pkg::RUN_BIT]; // RULE_14
            nxt_ff.coarse = WDATA[trocm_pkg::COARSE_LSB +: trocm_pkg::TRIM_W]; // RULE_15
            nxt_ff.fine   = WDATA[trocm_pkg::FINE_LSB +: trocm_pkg::TRIM_W]; // RULE_15
        end
        // Full hold stops the oscillator and wins over a same-cycle write.
        if (FULL_HOLD_ENTRY) begin
            nxt_ff.run = 1'b0; // RULE_21
        end
        // Only enable, range and test bits take writes in the high register.
        if (wr_hi) begin
            nxt_ff.en        = WDATA[trocm_pkg::EN_BIT]; // RULE_05
            nxt_ff.range_sel = WDATA[trocm_pkg::RANGE_BIT]; // RULE_10
            nxt_ff.test      = WDATA[trocm_pkg::TEST_BIT];
        end
        // Measurement sequencer.
        case (cur_ff.st)
            trocm_pkg::MS_IDLE: begin
                if (cur_ff.en && cur_ff.run) begin
                    nxt_ff.st = trocm_pkg::MS_ARM; // RULE_02
                end
            end
            trocm_pkg::MS_ARM: begin
                if (evt.ref_rise) begin
                    nxt_ff.st = trocm_pkg::MS_COUNT; // RULE_22
                end
            end
            trocm_pkg::MS_COUNT: begin
                if (OSC_TICK) begin
                    nxt_ff.cnt = inc[CW-1:0]; // RULE_01
                    if (inc[CW]) begin
                        nxt_ff.ovf = 1'b1; // RULE_04
                    end
                end
                if (evt.ref_rise) begin
                    nxt_ff.st   = trocm_pkg::MS_DONE; // RULE_02
                    nxt_ff.done = 1'b1; // RULE_07
                end
            end
            trocm_pkg::MS_DONE: begin
                nxt_ff.st = trocm_pkg::MS_DONE; // RULE_08
            end
            default: begin
                nxt_ff.st = trocm_pkg::MS_IDLE;
            end
        endcase
        // Clearing the enable aborts and wipes results, but a flag set by hardware in
        // the same cycle survives so that software still learns that the period ended.
        if (clr) begin
            nxt_ff.st   = trocm_pkg::MS_IDLE; // RULE_06
            nxt_ff.cnt  = '0;
            nxt_ff.ovf  = ovf_set; // RULE_23
            nxt_ff.done = done_set;
        end
        nxt_ff.at_ctr = (nxt_ff.coarse == trocm_pkg::CENTER_COARSE) &&
                        (nxt_ff.fine == trocm_pkg::CENTER_FINE); // RULE_16
        // Read data stand for exactly one cycle after the strobe.
        nxt_ff.rdata = 8'h00;
        if (RD) begin
            case (ADDR)
                trocm_pkg::OSC_CTRL_ADDR: begin
                    nxt_ff.rdata = {cur_ff.sel, cur_ff.run, cur_ff.coarse, cur_ff.fine};
                end
                trocm_pkg::CNT_LO_ADDR: begin
                    nxt_ff.rdata = cur_ff.cnt[7:0]; // RULE_03
                end
                trocm_pkg::CNT_MID_ADDR: begin
                    nxt_ff.rdata = cur_ff.cnt[15:8]; // RULE_03
                end
                trocm_pkg::CNT_HI_ADDR: begin
                    nxt_ff.rdata = {cur_ff.en, cur_ff.done, cur_ff.range_sel, cur_ff.test,
                                    cur_ff.ovf, cur_ff.cnt[CW-1:16]}; // RULE_03
                end
                default: begin
                    nxt_ff.rdata = 8'h00;
                end
            endcase
        end
    end

    // All state resets to zero; the oscillator is therefore stopped at reset.
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cur_ff           <= '0; // RULE_21
            cur_ff.sel       <= trocm_pkg::OSC_CTRL_RST[trocm_pkg::SEL_BIT];
            cur_ff.range_sel <= trocm_pkg::CNT_HI_RST[trocm_pkg::RANGE_BIT];
            cur_ff.st        <= trocm_pkg::MS_IDLE;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // Outputs straight from flip-flops, apart from the pause gate.
    assign RDATA            = cur_ff.rdata;
    assign OSC_RUN          = cur_ff.run;
    assign MAIN_CLK_SRC_SEL = cur_ff.sel;
    assign COARSE_TRIM      = cur_ff.coarse;
    assign FINE_TRIM        = cur_ff.fine;
    assign CENTER_RANGE_SEL = cur_ff.range_sel;
    assign TRIM_AT_CENTER   = cur_ff.at_ctr;
    assign SYS_CLK_PAUSE    = evt.pause_act;

    // Checks on the measurement and register behaviour.
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);

    sequence s_clear_req;
        wr_hi && !WDATA[trocm_pkg::EN_BIT];
    endsequence

    sequence s_rd_low;
        RD && (ADDR == trocm_pkg::CNT_LO_ADDR);
    endsequence

    property p_clear_all;
        s_clear_req |=> (cur_ff.cnt == '0) && !cur_ff.en && (cur_ff.ovf == $past(ovf_set))
                        && (cur_ff.done == $past(done_set));
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("enable clear left results"); // RULE_06

    property p_done_hold;
        (cur_ff.done && !clr) |=> cur_ff.done;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("done flag dropped early"); // RULE_07

    property p_ovf_set;
        (cur_ff.st == trocm_pkg::MS_COUNT && OSC_TICK && (&cur_ff.cnt) && !clr)
            |=> cur_ff.ovf && (cur_ff.cnt == '0);
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged"); // RULE_04

    property p_ovf_sticky;
        (cur_ff.ovf && !clr) |=> cur_ff.ovf;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost"); // RULE_23

    property p_no_restart;
        (cur_ff.st == trocm_pkg::MS_DONE && !clr)
            |=> (cur_ff.st == trocm_pkg::MS_DONE) && $stable(cur_ff.cnt);
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("measurement restarted"); // RULE_08

    property p_window;
        (cur_ff.st != trocm_pkg::MS_COUNT && !clr) |=> $stable(cur_ff.cnt);
    endproperty
    a_window: assert property (p_window) else $error("count moved outside window"); // RULE_02

    property p_rd_low;
        s_rd_low |=> RDATA == $past(cur_ff.cnt[7:0]);
    endproperty
    a_rd_low: assert property (p_rd_low) else $error("low count read wrong"); // RULE_03

    property p_done_ro;
        (wr_hi && WDATA[trocm_pkg::DONE_BIT] && !cur_ff.done
         && cur_ff.st != trocm_pkg::MS_COUNT) |=> !cur_ff.done;
    endproperty
    a_done_ro: assert property (p_done_ro) else $error("done flag took a write"); // RULE_05

    property p_hold_stop;
        FULL_HOLD_ENTRY |=> !OSC_RUN;
    endproperty
    a_hold_stop: assert property (p_hold_stop) else $error("oscillator ran after hold"); // RULE_14

    property p_pause_on_select;
        (serving && !cur_ff.serv_q) |=> SYS_CLK_PAUSE [*3];
    endproperty
    a_pause_on_select: assert property (p_pause_on_select) else $error("no pause on select"); // RULE_17

    // Direct checks of the rewrite pause, idle hold, register fields, read data and the done set event.
    property p_pause_on_write;
        (serving && wr_ctrl) |=> SYS_CLK_PAUSE [*3];
    endproperty
    a_pause_on_write: assert property (p_pause_on_write) else $error("no pause on rewrite"); // RULE_17

    property p_done_set;
        done_set |=> cur_ff.done && (cur_ff.st != trocm_pkg::MS_COUNT);
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag not set"); // RULE_07

    property p_idle_stopped;
        (cur_ff.st == trocm_pkg::MS_IDLE && !cur_ff.run) |=> cur_ff.st == trocm_pkg::MS_IDLE;
    endproperty
    a_idle_stopped: assert property (p_idle_stopped) else $error("armed while stopped"); // RULE_02

    property p_rd_high;
        (RD && ADDR == trocm_pkg::CNT_HI_ADDR) |=> RDATA[3:0] == $past({cur_ff.ovf, cur_ff.cnt[18:16]});
    endproperty
    a_rd_high: assert property (p_rd_high) else $error("high count read wrong"); // RULE_04

    property p_rd_mid;
        (RD && ADDR == trocm_pkg::CNT_MID_ADDR) |=> RDATA == $past(cur_ff.cnt[15:8]);
    endproperty
    a_rd_mid: assert property (p_rd_mid) else $error("middle count read wrong"); // RULE_03

    property p_rdata_idle;
        !RD |=> RDATA == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data held too long"); // RULE_03

    property p_ctrl_write;
        (wr_ctrl && !FULL_HOLD_ENTRY) |=> {MAIN_CLK_SRC_SEL, OSC_RUN, COARSE_TRIM, FINE_TRIM} == $past(WDATA);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored"); // RULE_15

    property p_range_write;
        wr_hi |=> CENTER_RANGE_SEL == $past(WDATA[trocm_pkg::RANGE_BIT]);
    endproperty
    a_range_write: assert property (p_range_write) else $error("range select not stored"); // RULE_10

    property p_at_center;
        TRIM_AT_CENTER == ((COARSE_TRIM == trocm_pkg::CENTER_COARSE) && (FINE_TRIM == trocm_pkg::CENTER_FINE));
    endproperty
    a_at_center: assert property (p_at_center) else $error("center indication wrong"); // RULE_16

endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the tunable RC oscillator control and measurement core.
// Assumes the core alone, driven straight through its register port and event inputs.
`timescale 1ns/1ps
module tb;
    // Clock and reset.
    logic        SYS_CLK;
    logic        SYS_RST;
    // Register port.
    logic [15:0] ADDR;
    logic [7:0]  WDATA;
    logic        WR;
    logic        RD;
    wire  [7:0]  RDATA;
    // Oscillator, reference and power state.
    logic        OSC_TICK;
    logic        REF_IN;
    logic        SYS_CLK_IS_MAIN;
    logic        FULL_HOLD_ENTRY;
    // Oscillator controls seen at the outputs.
    wire         OSC_RUN;
    wire         MAIN_CLK_SRC_SEL;
    wire  [2:0]  COARSE_TRIM;
    wire  [2:0]  FINE_TRIM;
    wire         CENTER_RANGE_SEL;
    wire         TRIM_AT_CENTER;
    wire         SYS_CLK_PAUSE;

    int          fails;
    int          n_compared;
    int          k;

    trocm_core dut (
        .SYS_CLK          (SYS_CLK),
        .SYS_RST          (SYS_RST),
        .ADDR             (ADDR),
        .WDATA            (WDATA),
        .WR               (WR),
        .RD               (RD),
        .RDATA            (RDATA),
        .OSC_TICK         (OSC_TICK),
        .REF_IN           (REF_IN),
        .SYS_CLK_IS_MAIN  (SYS_CLK_IS_MAIN),
        .FULL_HOLD_ENTRY  (FULL_HOLD_ENTRY),
        .OSC_RUN          (OSC_RUN),
        .MAIN_CLK_SRC_SEL (MAIN_CLK_SRC_SEL),
        .COARSE_TRIM      (COARSE_TRIM),
        .FINE_TRIM        (FINE_TRIM),
        .CENTER_RANGE_SEL (CENTER_RANGE_SEL),
        .TRIM_AT_CENTER   (TRIM_AT_CENTER),
        .SYS_CLK_PAUSE    (SYS_CLK_PAUSE)
    );

    // Free-running 125 MHz clock.
    initial begin
        SYS_CLK = 1'b0;
        forever #4 SYS_CLK = ~SYS_CLK;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("Compared %0d values, %0d mismatches", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Case-equality compare so that an unknown never counts as a match.
    task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One-cycle write; the value is visible once the taking edge has passed.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge SYS_CLK);
        WR    <= 1'b0;
    endtask

    // One-cycle read; the data stand only in the cycle after the strobe.
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge SYS_CLK);
        RD   <= 1'b0;
        #1;
        d = RDATA;
    endtask

    // Read and compare in one call.
    task automatic rdc(input logic [15:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        rd(a, d);
        chk(nm, {12'h000, d}, {12'h000, e});
    endtask

    // One full reference period with n oscillator ticks well inside it.
    // A held tick level gives one tick per clock, which keeps long counts short.
    task automatic ref_period(input int n, input logic hold);
        @(posedge SYS_CLK);
        REF_IN <= 1'b1;
        repeat (8) @(posedge SYS_CLK);
        if (hold) begin
            OSC_TICK <= 1'b1;
            repeat (n) @(posedge SYS_CLK);
            OSC_TICK <= 1'b0;
        end else begin
            repeat (n) begin
                OSC_TICK <= 1'b1;
                @(posedge SYS_CLK);
                OSC_TICK <= 1'b0;
                @(posedge SYS_CLK);
            end
        end
        repeat (8) @(posedge SYS_CLK);
        REF_IN <= 1'b0;
        repeat (8) @(posedge SYS_CLK);
        REF_IN <= 1'b1;
        repeat (8) @(posedge SYS_CLK);
        REF_IN <= 1'b0;
        repeat (8) @(posedge SYS_CLK);
    endtask

    // Counts pause cycles over a window that starts at the taking edge.
    task automatic count_pause(output int n);
        n = 0;
        repeat (8) begin
            #1;
            if (SYS_CLK_PAUSE === 1'b1) n++;
            @(posedge SYS_CLK);
        end
    endtask

    // Watchdog above the whole run, whose longest measurement takes about 66k cycles.
    initial begin
        repeat (90000) @(posedge SYS_CLK);
        fails++;
        report_and_stop();
    end

    // Main sequence.
    initial begin
        fails           = 0;
        n_compared      = 0;
        SYS_RST         = 1'b1;
        ADDR            = 16'h0000;
        WDATA           = 8'h00;
        WR              = 1'b0;
        RD              = 1'b0;
        OSC_TICK        = 1'b0;
        REF_IN          = 1'b0;
        SYS_CLK_IS_MAIN = 1'b0;
        FULL_HOLD_ENTRY = 1'b0;
        repeat (16) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;

        // Reset state of every register and output.
        for (int i = 0; i < 4; i++) begin
            rdc(trocm_pkg::OSC_CTRL_ADDR + 16'(i), 8'h00, "reset value");
        end
        @(posedge SYS_CLK);
        #1;
        chk("rdata after slot", {12'h000, RDATA}, 20'h0_0000);
        chk("outputs at reset", {OSC_RUN, MAIN_CLK_SRC_SEL, COARSE_TRIM, FINE_TRIM, CENTER_RANGE_SEL,
            TRIM_AT_CENTER, SYS_CLK_PAUSE}, 20'h0_0000);

        // Every coarse and fine code, with the run bit set.
        for (int i = 0; i < 8; i++) begin
            wr(trocm_pkg::OSC_CTRL_ADDR, 8'h40 | 8'(i << 3) | 8'(7 - i));
            #1;
            chk("coarse trim", {17'h0_0000, COARSE_TRIM}, 20'(i));
            chk("fine trim", {17'h0_0000, FINE_TRIM}, 20'(7 - i));
            chk("run", {19'h0_0000, OSC_RUN}, 20'h0_0001);
            chk("off center", {19'h0_0000, TRIM_AT_CENTER}, 20'h0_0000);
        end
        wr(trocm_pkg::OSC_CTRL_ADDR, 8'h60);
        #1;
        chk("at center", {19'h0_0000, TRIM_AT_CENTER}, 20'h0_0001);
        wr(trocm_pkg::OSC_CTRL_ADDR, 8'h80);
        #1;
        chk("main select", {18'h0_0000, MAIN_CLK_SRC_SEL, OSC_RUN}, 20'h0_0002);
        rdc(trocm_pkg::OSC_CTRL_ADDR, 8'h80, "control readback");
        wr(trocm_pkg::OSC_CTRL_ADDR, 8'h40);

        // Read-only bits in the high register and an unmapped place.
        wr(trocm_pkg::CNT_HI_ADDR, 8'h6f);
        rdc(trocm_pkg::CNT_HI_ADDR, 8'h20, "high writable bits");
        chk("range 4 MHz", {19'h0_0000, CENTER_RANGE_SEL}, 20'h0_0001);
        wr(trocm_pkg::CNT_HI_ADDR, 8'h00);
        #1;
        chk("range 10 MHz", {19'h0_0000, CENTER_RANGE_SEL}, 20'h0_0000);
        wr(16'hfeb3, 8'hff);
        rdc(trocm_pkg::OSC_CTRL_ADDR, 8'h40, "unmapped write");
        rdc(16'hfeb8, 8'h00, "unmapped read");

        // Short measurement, then refused writes and a refused restart.
        wr(trocm_pkg::CNT_HI_ADDR, 8'h80);
        ref_period(37, 1'b0);
        rdc(trocm_pkg::CNT_HI_ADDR, 8'hc0, "done flag");
        rdc(trocm_pkg::CNT_LO_ADDR, 8'h25, "count low");
        rdc(trocm_pkg::CNT_MID_ADDR, 8'h00, "count mid");
        wr(trocm_pkg::CNT_LO_ADDR, 8'hff);
        wr(trocm_pkg::CNT_MID_ADDR, 8'hff);
        wr(trocm_pkg::CNT_HI_ADDR, 8'h80);
        ref_period(5, 1'b0);
        rdc(trocm_pkg::CNT_LO_ADDR, 8'h25, "no restart");
        rdc(trocm_pkg::CNT_MID_ADDR, 8'h00, "mid read-only");
        rdc(trocm_pkg::CNT_HI_ADDR, 8'hc0, "done holds");
        wr(trocm_pkg::CNT_HI_ADDR, 8'h00);
        rdc(trocm_pkg::CNT_LO_ADDR, 8'h00, "clear low");
        rdc(trocm_pkg::CNT_HI_ADDR, 8'h00, "clear done");

        // Count past 16 bits so the high register carries bit 16.
        wr(trocm_pkg::CNT_HI_ADDR, 8'h80);
        ref_period(65541, 1'b1);
        rdc(trocm_pkg::CNT_HI_ADDR, 8'hc1, "long high");
        rdc(trocm_pkg::CNT_LO_ADDR, 8'h05, "long low");
        rdc(trocm_pkg::CNT_MID_ADDR, 8'h00, "long mid");
        wr(trocm_pkg::CNT_HI_ADDR, 8'h00);
        rdc(trocm_pkg::CNT_HI_ADDR, 8'h00, "clear high");

        // Pause on becoming the system clock and on a rewrite while serving.
        @(posedge SYS_CLK);
        SYS_CLK_IS_MAIN <= 1'b1;
        wr(trocm_pkg::OSC_CTRL_ADDR, 8'hc0);
        count_pause(k);
        chk("pause on select", 20'(k), 20'(trocm_pkg::PAUSE_CYC));
        wr(trocm_pkg::OSC_CTRL_ADDR, 8'hc4);
        count_pause(k);
        chk("pause on rewrite", 20'(k), 20'(trocm_pkg::PAUSE_CYC));
        SYS_CLK_IS_MAIN <= 1'b0;

        // Full hold stops the oscillator and leaves the other control bits.
        @(posedge SYS_CLK);
        FULL_HOLD_ENTRY <= 1'b1;
        @(posedge SYS_CLK);
        FULL_HOLD_ENTRY <= 1'b0;
        #1;
        chk("hold stops run", {19'h0_0000, OSC_RUN}, 20'h0_0000);
        rdc(trocm_pkg::OSC_CTRL_ADDR, 8'h84, "hold readback");

        // With the oscillator stopped, enabling measurement counts nothing.
        wr(trocm_pkg::CNT_HI_ADDR, 8'h80);
        ref_period(10, 1'b0);
        rdc(trocm_pkg::CNT_LO_ADDR, 8'h00, "stopped count");
        rdc(trocm_pkg::CNT_HI_ADDR, 8'h80, "stopped no done");
        report_and_stop();
    end
endmodule
